// ### design/tei_info.sv
// Transition error information register with its detectors.
`timescale 1ns/1ps
`include "tei_regs.svh"

module tei_info
    import tei_pkg::*;
#(
    parameter int LVL_W         = 3,
    parameter int MAX_TRAP_LVL  = 5
)
(
    // Clock and hard power-on reset.
    input  wire logic            ref_clk_i,
    input  wire logic            sys_rst_i,
    // Register access port.
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic [63:0]     reg_wdata_i,
    output logic [63:0]          reg_rdata_o,
    output logic                 reg_rvalid_o,
    // Resets that keep the register.
    input  wire logic            por_event_i,
    input  wire logic            watchdog_reset_event_i,
    input  wire logic            external_reset_event_i,
    // Live error control settings.
    input  wire logic            lenient_detect_i,
    input  wire logic            handler_active_i,
    // Degrade requests.
    input  wire logic            transition_degrade_module_i,
    input  wire logic            transition_degrade_core_i,
    input  wire logic            urgent_degrade_module_i,
    input  wire logic            urgent_degrade_core_i,
    // Uncorrectable error reports.
    input  wire logic            l2_unmarked_uncorrectable_i,
    input  wire logic            l1_unmarked_uncorrectable_i,
    input  wire logic            control_reg_uncorrectable_i,
    input  wire logic            trap_vector_fault_i,
    // Trap and timeout events.
    input  wire logic [LVL_W-1:0] trap_level_i,
    input  wire logic            trap_taken_i,
    input  wire logic            watchdog_timeout_i,
    input  wire logic            async_data_fault_taken_i,
    input  wire logic            software_initiated_reset_i,
    // Suspend and wake events.
    input  wire logic            suspend_req_i,
    input  wire logic            interrupt_vector_i,
    input  wire logic            interrupt_level_i,
    input  wire logic            error_identity_reg_ue_i,
    input  wire logic            system_tick_ue_i,
    input  wire logic            cycle_tick_ue_i,
    // Status out.
    output logic                 suspended_o,
    output logic                 transition_error_o,
    output logic [2:0]           urgent_error_status_set_o,
    output logic [63:0]          transition_error_info_o
);

    localparam logic [LVL_W-1:0] MAX_LVL = LVL_W'(MAX_TRAP_LVL);

    tei_word_t info_ff;
    tei_word_t nxt_info;
    tei_word_t hw_set;
    tei_word_t sw_set;
    logic [63:0] rdata_ff;
    logic        rvalid_ff;
    logic        hit;
    logic        clr;
    logic        save;
    logic        at_max;
    logic        wake;
    logic        escal;

    ////////////////////////////////////////////////////////////////////////

    assign hit    = (reg_addr_i == `TEI_INFO_OFFSET);
    assign clr    = reg_wr_i && hit
                    && reg_wdata_i[`TEI_B_CLEAR_ALL];
    assign save   = por_event_i || watchdog_reset_event_i;
    assign at_max = (trap_level_i == MAX_LVL);
    assign wake   = por_event_i || watchdog_reset_event_i
                    || external_reset_event_i || interrupt_vector_i
                    || interrupt_level_i;

    ////////////////////////////////////////////////////////////////////////

    tei_suspend u_suspend (
        .ref_clk_i     (ref_clk_i),
        .sys_rst_i     (sys_rst_i),
        .suspend_req_i (suspend_req_i),
        .wake_i        (wake),
        .wake_res_ue_i ({cycle_tick_ue_i, system_tick_ue_i,
                         error_identity_reg_ue_i}),
        .suspended_o   (suspended_o),
        .escalate_o    (escal),
        .status_set_o  (urgent_error_status_set_o)
    );

    assign transition_error_o = escal;

    ////////////////////////////////////////////////////////////////////////

    // Hardware set sources; thread degrade bits have none.
    always_comb
    begin
        hw_set = 64'h0;
        hw_set[`TEI_B_TR_MODULE]  = transition_degrade_module_i;
        hw_set[`TEI_B_TR_CORE]    = transition_degrade_core_i;
        hw_set[`TEI_B_UG_MODULE]  = urgent_degrade_module_i;
        hw_set[`TEI_B_UG_CORE]    = urgent_degrade_core_i
                                    || escal;
        hw_set[`TEI_B_L2_UE]      = l2_unmarked_uncorrectable_i;
        hw_set[`TEI_B_L1_UE]      = l1_unmarked_uncorrectable_i;
        hw_set[`TEI_B_CTRL_UE]    = control_reg_uncorrectable_i;
        hw_set[`TEI_B_TRAP_VEC]   = trap_vector_fault_i;
        hw_set[`TEI_B_WDT_MAX]    = watchdog_timeout_i
                                    && at_max;
        hw_set[`TEI_B_SECOND_WDT] = watchdog_timeout_i
                                    && async_data_fault_taken_i;
        hw_set[`TEI_B_SOFT_MAX]   = software_initiated_reset_i
                                    && at_max;
        hw_set[`TEI_B_TRAP_MAX]   = trap_taken_i && at_max;
    end

    // Software may only set writable bits, so only bit 0 of a write can clear.
    assign sw_set = (reg_wr_i && hit)
                    ? (reg_wdata_i & `TEI_SW_SET_MASK) : 64'h0;

    // Set wins over the clear issued in the same cycle.
    always_comb
    begin
        nxt_info = clr ? `TEI_INFO_RESET : info_ff;
        nxt_info = nxt_info | hw_set | sw_set;
        if (save)
        begin
            nxt_info[`TEI_B_SAVED_LENIENT] = lenient_detect_i;
            nxt_info[`TEI_B_SAVED_HANDLER] = handler_active_i;
        end
        nxt_info = nxt_info & `TEI_IMPL_MASK;
    end

    // Only the hard reset clears; other resets arrive as events.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            info_ff <= `TEI_INFO_RESET;
        end
        else
        begin
            info_ff <= nxt_info;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Unmapped addresses read as zero; bit 0 always reads zero.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rdata_ff  <= 64'h0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= reg_rd_i;
            if (reg_rd_i)
            begin
                rdata_ff <= hit ? info_ff : 64'h0;
            end
        end
    end

    assign reg_rdata_o             = rdata_ff;
    assign reg_rvalid_o            = rvalid_ff;
    assign transition_error_info_o = info_ff;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_clear_alone;
        clr && !save && (hw_set == 64'h0) && (sw_set == 64'h0);
    endsequence

    sequence s_save_req;
        save;
    endsequence

    a_clear_all_zero: assert property (
        s_clear_alone |=> (info_ff == 64'h0))
        else $error("Clear-all write left bits set.");

    a_sticky_hold: assert property (
        !clr && !save |=> ((info_ff & $past(info_ff)) == $past(info_ff)))
        else $error("Sticky bit dropped without a clear.");

    a_set_beats_clr: assert property (
        clr && hw_set[`TEI_B_L2_UE] |=> info_ff[`TEI_B_L2_UE])
        else $error("Event lost against a clear.");

    a_save_lenient: assert property (
        s_save_req |=> info_ff[`TEI_B_SAVED_LENIENT]
                       == $past(lenient_detect_i))
        else $error("Lenient detect not saved on reset.");

    a_save_handler: assert property (
        s_save_req |=> info_ff[`TEI_B_SAVED_HANDLER]
                       == $past(handler_active_i))
        else $error("Handler active not saved on reset.");

    a_thread_no_hw: assert property (
        !(reg_wr_i && hit) |=> $stable(info_ff[`TEI_B_TR_THREAD])
                               || $past(clr))
        else $error("Thread degrade bit changed by hardware.");

    a_other_zero: assert property (
        ##1 !info_ff[`TEI_B_OTHER] && !info_ff[`TEI_B_CLEAR_ALL])
        else $error("Other cause or clear bit read as one.");

    a_wdt_at_max: assert property (
        watchdog_timeout_i && trap_level_i == MAX_LVL
        |=> info_ff[`TEI_B_WDT_MAX])
        else $error("Timeout at max level not recorded.");

    a_second_wdt: assert property (
        watchdog_timeout_i && async_data_fault_taken_i
        |=> info_ff[`TEI_B_SECOND_WDT])
        else $error("Second timeout not recorded.");

    a_trap_not_max: assert property (
        trap_taken_i && trap_level_i != MAX_LVL && !info_ff[`TEI_B_TRAP_MAX]
        && !sw_set[`TEI_B_TRAP_MAX] |=> !info_ff[`TEI_B_TRAP_MAX])
        else $error("Trap below max level was recorded.");

    a_escal_core: assert property (
        escal |=> info_ff[`TEI_B_UG_CORE])
        else $error("Escalation did not set urgent core bit.");

    a_read_data: assert property (
        reg_rd_i && hit |=> reg_rvalid_o
                            && reg_rdata_o == $past(info_ff))
        else $error("Read data does not match the register.");

endmodule : tei_info

// ### design/tei_regs.svh
// Offsets, field positions and reset values of the transition error register.
// Overview of operation
// - Hard power-on clears; other resets keep fields.
// - Each detected condition sets its own bit.
// - Writing one to bit 0 clears all.
// - Hardware never clears a set sticky bit.
// - Power-on or watchdog reset saves lenient detect.
// - Power-on or watchdog reset saves handler active.
// - Transition error module degrade sets bit 23.
// - Transition error core degrade sets bit 22.
// - Thread degrade bits only set by software.
// - Urgent error module degrade sets bit 20.
// - Urgent error core degrade sets bit 19.
// - Unmarked cache errors set bits 17, 16.
// - Control register uncorrectable error sets bit 15.
// - Other cause bit 14 always reads zero.
// - Trap vector fault sets bit 13.
// - Timeout at max trap level sets bit 11.
// - Second timeout after async fault sets 10.
// - Soft reset at max level sets bit 9.
// - Trap at max level sets bit 8.
// - Suspended thread wakes only on listed events.
// - Suspended wake-resource urgent error becomes transition error.
// - Escalation sets urgent core bit and status bit.
`ifndef TEI_REGS_SVH
`define TEI_REGS_SVH

`define TEI_INFO_OFFSET     8'h18
`define TEI_INFO_RESET      64'h0000_0000_0000_0000
`define TEI_IMPL_MASK       64'h0000_0003_00ff_af00
`define TEI_SW_SET_MASK     64'h0000_0000_00ff_0000
`define TEI_B_SAVED_LENIENT 33
`define TEI_B_SAVED_HANDLER 32
`define TEI_B_TR_MODULE     23
`define TEI_B_TR_CORE       22
`define TEI_B_TR_THREAD     21
`define TEI_B_UG_MODULE     20
`define TEI_B_UG_CORE       19
`define TEI_B_UG_THREAD     18
`define TEI_B_L2_UE         17
`define TEI_B_L1_UE         16
`define TEI_B_CTRL_UE       15
`define TEI_B_OTHER         14
`define TEI_B_TRAP_VEC      13
`define TEI_B_WDT_MAX       11
`define TEI_B_SECOND_WDT    10
`define TEI_B_SOFT_MAX      9
`define TEI_B_TRAP_MAX      8
`define TEI_B_CLEAR_ALL     0

`endif

// ### design/tei_pkg.sv
// Types shared by the transition error block.
package tei_pkg;

    typedef enum logic [1:0] {
        tei_st_run  = 2'b01,
        tei_st_susp = 2'b10
    } tei_thr_state_t;

    typedef logic [63:0] tei_word_t;

endpackage : tei_pkg

// ### design/tei_suspend.sv
// Suspend state tracker and escalation of wake-resource urgent errors.
`timescale 1ns/1ps

module tei_suspend
    import tei_pkg::*;
(
    // Clock and hard reset.
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // Suspend entry and wake events.
    input  wire logic       suspend_req_i,
    input  wire logic       wake_i,
    // Urgent errors in wake resources.
    input  wire logic [2:0] wake_res_ue_i,
    // Results.
    output logic            suspended_o,
    output logic            escalate_o,
    output logic [2:0]      status_set_o
);

    tei_thr_state_t state_ff;
    tei_thr_state_t nxt_state;
    logic           escalate_ff;
    logic [2:0]     status_set_ff;
    logic           hit;

    ////////////////////////////////////////////////////////////////////////

    // Wake wins over a new suspend so a waking thread is never lost.
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            tei_st_run:
            begin
                if (suspend_req_i && !wake_i)
                begin
                    nxt_state = tei_st_susp;
                end
            end
            tei_st_susp:
            begin
                if (wake_i)
                begin
                    nxt_state = tei_st_run;
                end
            end
            default:
            begin
                nxt_state = tei_st_run;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_ff <= tei_st_run;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign hit = (state_ff == tei_st_susp) && (|wake_res_ue_i);

    // A stuck wake resource would strand the thread, so it is escalated.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            escalate_ff   <= 1'b0;
            status_set_ff <= 3'h0;
        end
        else
        begin
            escalate_ff   <= hit;
            status_set_ff <= hit ? wake_res_ue_i : 3'h0;
        end
    end

    assign suspended_o  = (state_ff == tei_st_susp);
    assign escalate_o   = escalate_ff;
    assign status_set_o = status_set_ff;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_susp_escal: assert property (
        hit |=> escalate_o && (status_set_o == $past(wake_res_ue_i)))
        else $error("Suspended resource error was not escalated.");

    a_susp_stays: assert property (
        suspended_o && !wake_i |=> suspended_o)
        else $error("Thread left suspend without a wake event.");

    a_run_no_escal: assert property (
        !suspended_o |=> !escalate_o)
        else $error("Escalation while the thread was running.");

endmodule : tei_suspend

// ### test/tb.sv
// Self-checking testbench for the transition error information register.
`timescale 1ns/1ps

module tb
    import tei_pkg::*;
;

////////////////////////////////////////////////////////////////////////////
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  addr;
    tei_word_t   wdata;
    tei_word_t   rdata;
    tei_word_t   info;
    logic        rvalid;
    logic        susp;
    logic        terr;
    logic [2:0]  sset;
    logic [2:0]  lvl;
    logic        lenient;
    logic        handler;
    logic        adf;
    logic [19:0] p;
    int          err_total;
    int          num_checks;
    int          cyc;
    tei_word_t   exp_v;
    int          pos [8] = '{23, 22, 20, 19, 17, 16, 15, 13};

    always #20 ref_clk_i = ~ref_clk_i;

////////////////////////////////////////////////////////////////////////////
    tei_info #(.LVL_W(3), .MAX_TRAP_LVL(5)) DUT (
        .ref_clk_i                   (ref_clk_i),
        .sys_rst_i                   (sys_rst_i),
        .reg_wr_i                    (reg_wr),
        .reg_rd_i                    (reg_rd),
        .reg_addr_i                  (addr),
        .reg_wdata_i                 (wdata),
        .reg_rdata_o                 (rdata),
        .reg_rvalid_o                (rvalid),
        .por_event_i                 (p[15]),
        .watchdog_reset_event_i      (p[16]),
        .external_reset_event_i      (p[14]),
        .lenient_detect_i            (lenient),
        .handler_active_i            (handler),
        .transition_degrade_module_i (p[0]),
        .transition_degrade_core_i   (p[1]),
        .urgent_degrade_module_i     (p[2]),
        .urgent_degrade_core_i       (p[3]),
        .l2_unmarked_uncorrectable_i (p[4]),
        .l1_unmarked_uncorrectable_i (p[5]),
        .control_reg_uncorrectable_i (p[6]),
        .trap_vector_fault_i         (p[7]),
        .trap_level_i                (lvl),
        .trap_taken_i                (p[8]),
        .watchdog_timeout_i          (p[9]),
        .async_data_fault_taken_i    (adf),
        .software_initiated_reset_i  (p[10]),
        .suspend_req_i               (p[11]),
        .interrupt_vector_i          (p[12]),
        .interrupt_level_i           (p[13]),
        .error_identity_reg_ue_i     (p[17]),
        .system_tick_ue_i            (p[18]),
        .cycle_tick_ue_i             (p[19]),
        .suspended_o                 (susp),
        .transition_error_o          (terr),
        .urgent_error_status_set_o   (sset),
        .transition_error_info_o     (info)
    );

////////////////////////////////////////////////////////////////////////////
    task automatic chk(input tei_word_t got, input tei_word_t exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Strobes are held for exactly one rising edge.
    task automatic pulse(input int k);
        @(negedge ref_clk_i);
        p[k] = 1'b1;
        @(negedge ref_clk_i);
        p[k] = 1'b0;
    endtask : pulse

    task automatic wr(input logic [7:0] a, input tei_word_t d);
        @(negedge ref_clk_i);
        reg_wr = 1'b1;
        addr   = a;
        wdata  = d;
        @(negedge ref_clk_i);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input tei_word_t e);
        @(negedge ref_clk_i);
        reg_rd = 1'b1;
        addr   = a;
        @(negedge ref_clk_i);
        reg_rd = 1'b0;
        chk({63'h0, rvalid}, 64'h1);
        chk(rdata, e);
    endtask : rd

    // A hang is cut short well above the 120 or so cycles the run needs.
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            $display("[FAIL] %0t run did not finish", $time);
            test_done();
        end
    end

////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_wr, reg_rd, lenient, handler, adf} = '0;
        addr = 8'h00;
        wdata = 64'h0;
        lvl = 3'h0;
        p = 20'h0;
        sys_rst_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        rd(8'h18, 64'h0);
        $display("test reset done");

        exp_v = 64'h0;
        for (int k = 0; k < 8; k++)
        begin
            pulse(k);
            exp_v[pos[k]] = 1'b1;
            chk(info, exp_v);
        end
        wr(8'h18, 64'h0);
        rd(8'h18, exp_v);
        wr(8'h18, 64'hffff_ffff_ffff_fffe);
        exp_v = exp_v | 64'h0000_0000_00ff_0000;
        rd(8'h18, exp_v);
        wr(8'h20, 64'h1);
        rd(8'h18, exp_v);
        rd(8'h20, 64'h0);
        wr(8'h18, 64'h1);
        rd(8'h18, 64'h0);
        @(negedge ref_clk_i);
        {reg_wr, p[4]} = 2'b11;
        addr = 8'h18;
        wdata = 64'h1;
        @(negedge ref_clk_i);
        {reg_wr, p[4]} = 2'b00;
        chk(info, 64'h2_0000);
        wr(8'h18, 64'h1);
        chk(info, 64'h0);
        $display("test events done");

        lvl = 3'h4;
        pulse(8);
        pulse(9);
        pulse(10);
        chk(info, 64'h0);
        adf = 1'b1;
        pulse(9);
        adf = 1'b0;
        chk(info, 64'h400);
        lvl = 3'h5;
        pulse(8);
        chk(info, 64'h500);
        pulse(10);
        chk(info, 64'h700);
        pulse(9);
        chk(info, 64'hf00);
        wr(8'h18, 64'h1);
        lvl = 3'h0;
        $display("test trap level done");

        lenient = 1'b1;
        pulse(0);
        pulse(15);
        chk(info, 64'h2_0080_0000);
        lenient = 1'b0;
        handler = 1'b1;
        pulse(16);
        chk(info, 64'h1_0080_0000);
        @(negedge ref_clk_i);
        sys_rst_i = 1'b1;
        @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        chk(info, 64'h0);
        $display("test save done");

        pulse(19);
        chk({63'h0, terr}, 64'h0);
        for (int w = 12; w < 17; w++)
        begin
            pulse(11);
            pulse(8);
            chk({63'h0, susp}, 64'h1);
            pulse(w);
            chk({63'h0, susp}, 64'h0);
        end
        wr(8'h18, 64'h1);
        pulse(11);
        for (int e = 17; e < 20; e++)
        begin
            pulse(e);
            chk({63'h0, terr}, 64'h1);
            chk({61'h0, sset}, 64'h1 << (e - 17));
            @(negedge ref_clk_i);
            chk(info, 64'h8_0000);
            chk({63'h0, susp}, 64'h1);
        end
        $display("test suspend done");
        test_done();
    end

endmodule : tb
